// ### afs_cfg.svh
// Constants of the auxiliary function strobe controller: offsets, fields, resets, timing.
// Assumes a single 10 MHz clock and APB register access with 32-bit data.
// Behaviour
// R1 - A block's M value of up to eight decimal digits is put on the code lines and its strobe is raised.
// R2 - One M per block is taken normally, up to three when triple-M mode is set, each on its own group.
// R3 - A value with more digits than the configured maximum for its function raises an alarm.
// R4 - The strobe goes high only after the configured strobe delay has passed since the codes were driven.
// R5 - Code lines carry the commanded value in plain binary.
// R6 - Motion and the other functions of the block start in the same cycle as the code output.
// R7 - The logic controller samples the code lines only once it sees the strobe high.
// R8 - Motion done goes high when the block's movement is finished; dependent actions wait for it.
// R9 - The logic controller raises the shared completion only when all active functions are finished.
// R10 - Strobes fall once completion has stayed high for longer than the configured hold time.
// R11 - The logic controller drops completion after it sees the strobes fall.
// R12 - When completion returns low all code lines are cleared, ending the sequence.
// R13 - No new block is taken until every handshake and the motion of the current one have finished.
// R14 - A controller reset during execution forces all strobes low well within 16 ms.
// R15 - While the lockout input is high no code lines and no strobes are output for new blocks.
// R16 - Each function group has its own code lines and strobe, all sharing one completion input.
// R17 - After reset codes, strobes and motion done are zero and the sequencer is idle.
`ifndef AFS_CFG_SVH
`define AFS_CFG_SVH

`define AFS_ADDR_CTRL 12'h000
`define AFS_ADDR_STROBE_DELAY 12'h004
`define AFS_ADDR_HOLD_TIME 12'h008
`define AFS_ADDR_DIGITS 12'h00C
`define AFS_ADDR_STATUS 12'h010
`define AFS_ADDR_IRQ_STATUS 12'h014
`define AFS_ADDR_IRQ_CLEAR 12'h018
`define AFS_ADDR_IRQ_ENABLE 12'h01C

`define AFS_CTRL_TRIPLE_BIT 0
`define AFS_DIGITS_M_LSB 0
`define AFS_DIGITS_S_LSB 4
`define AFS_DIGITS_T_LSB 8
`define AFS_STATUS_BUSY_BIT 0
`define AFS_STATUS_MDONE_BIT 1
`define AFS_STATUS_LOCK_BIT 2
`define AFS_STATUS_COMPLETE_BIT 3
`define AFS_STATUS_STROBE_LSB 4
`define AFS_IRQ_ALARM_BIT 0
`define AFS_IRQ_DONE_BIT 1
`define AFS_IRQ_ABORT_BIT 2

`define AFS_FN_AUX 0
`define AFS_FN_SECOND 1
`define AFS_FN_THIRD 2
`define AFS_FN_SPINDLE 3
`define AFS_FN_TOOL 4

`define AFS_RST_STROBE_DELAY 16'h0040
`define AFS_RST_HOLD_TIME 16'h0008
`define AFS_RST_DIGITS 12'h888

`define AFS_CLK_HZ 10000000
`define AFS_MS_PER_S 1000
`define AFS_CYCLES_PER_MS (`AFS_CLK_HZ / `AFS_MS_PER_S)
`define AFS_RESET_DROP_MS 16

`endif

// ### afs_pkg.sv
// Types shared by the auxiliary function strobe controller.
// Assumes the constants header is included where numbers are needed.
package afs_pkg;
	typedef logic [31:0] afs_word_t;
	typedef logic [15:0] afs_half_t;
	typedef logic [4:0] afs_fnmask_t;
	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_STROBE, ST_HOLD, ST_RELEASE, ST_FINISH} afs_state_e;
endpackage

// ### afs_ms_timer.sv
// Millisecond timer used for the strobe delay and the completion hold time.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module afs_ms_timer #(
	parameter int unsigned CYCLES_PER_MS = 10000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [15:0] durationMs,
	// Result
	output logic expired
);
	localparam logic [31:0] LastCycle = 32'(CYCLES_PER_MS - 1);
	logic [31:0] cycleCnt;
	logic [15:0] msLeft;
	logic running;

	always_ff @(posedge sys_clk)
	begin
		if (reset || abort)
		begin
			running <= 1'b0;
			cycleCnt <= 32'h0;
			msLeft <= 16'h0;
			expired <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (start)
			begin
				cycleCnt <= 32'h0;
				msLeft <= durationMs;
				running <= (durationMs != 16'h0);
				expired <= (durationMs == 16'h0);
			end
			else if (running)
			begin
				if (cycleCnt == LastCycle)
				begin
					cycleCnt <= 32'h0;
					msLeft <= msLeft - 16'h1;
					if (msLeft == 16'h1)
					begin
						running <= 1'b0;
						expired <= 1'b1;
					end
				end
				else
				begin
					cycleCnt <= cycleCnt + 32'h1;
				end
			end
		end
	end
endmodule // afs_ms_timer
`default_nettype wire

// ### afs_strobe_ctrl.sv
// Auxiliary function code and strobe sequencer with its APB register file.
// Assumes completion and lockout arrive from outside pins; block, motion and reset from local logic.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "afs_cfg.svh"
module afs_strobe_ctrl #(
	parameter int unsigned CYCLES_PER_MS = `AFS_CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire afs_pkg::afs_word_t pwdata,
	output logic pready,
	output afs_pkg::afs_word_t prdata,
	output logic pslverr,
	// Block from the interpreter
	input wire logic blockValid,
	output logic blockReady,
	input wire logic [1:0] blockMCount,
	input wire afs_pkg::afs_word_t blockAux,
	input wire afs_pkg::afs_half_t blockSecondAux,
	input wire afs_pkg::afs_half_t blockThirdAux,
	input wire logic blockSpindleValid,
	input wire afs_pkg::afs_word_t blockSpindle,
	input wire logic blockToolValid,
	input wire afs_pkg::afs_word_t blockTool,
	input wire logic blockHasMotion,
	// Motion and controller reset
	output logic motionStart,
	input wire logic motionFinished,
	input wire logic cncReset,
	// Logic controller side
	input wire logic functionComplete,
	input wire logic auxLockout,
	output afs_pkg::afs_word_t auxCode,
	output afs_pkg::afs_half_t secondAuxCode,
	output afs_pkg::afs_half_t thirdAuxCode,
	output afs_pkg::afs_word_t spindleCode,
	output afs_pkg::afs_word_t toolCode,
	output logic auxStrobe,
	output logic secondAuxStrobe,
	output logic thirdAuxStrobe,
	output logic spindleStrobe,
	output logic toolStrobe,
	output logic motionDone,
	// Interrupt
	output logic irq
);
	import afs_pkg::*;

	// True when the value needs more decimal digits than allowed.
	function automatic logic exceedsDigits(input afs_word_t value, input logic [3:0] maxDigits);
		afs_word_t limit;
		logic unlimited;
		begin
			unlimited = 1'b0;
			case (maxDigits)
				4'h0: limit = 32'h00000001;
				4'h1: limit = 32'h0000000A;
				4'h2: limit = 32'h00000064;
				4'h3: limit = 32'h000003E8;
				4'h4: limit = 32'h00002710;
				4'h5: limit = 32'h000186A0;
				4'h6: limit = 32'h000F4240;
				4'h7: limit = 32'h00989680;
				4'h8: limit = 32'h05F5E100;
				4'h9: limit = 32'h3B9ACA00;
				default:
				begin
					limit = 32'h0;
					unlimited = 1'b1;
				end
			endcase
			exceedsDigits = !unlimited && (value >= limit);
		end
	endfunction

	function automatic logic isMapped(input logic [11:0] addr);
		case (addr)
			`AFS_ADDR_CTRL, `AFS_ADDR_STROBE_DELAY, `AFS_ADDR_HOLD_TIME, `AFS_ADDR_DIGITS,
			`AFS_ADDR_STATUS, `AFS_ADDR_IRQ_STATUS, `AFS_ADDR_IRQ_CLEAR, `AFS_ADDR_IRQ_ENABLE:
				isMapped = 1'b1;
			default:
				isMapped = 1'b0;
		endcase
	endfunction

	afs_state_e state;
	logic tripleEnable;
	logic [15:0] strobeDelayMs;
	logic [15:0] holdTimeMs;
	logic [11:0] maxDigits;
	logic [2:0] irqStatus;
	logic [2:0] irqEnable;
	logic completeMeta;
	logic completeSync;
	logic lockMeta;
	logic lockSync;
	afs_fnmask_t strobeVec;
	afs_fnmask_t next_mask;
	logic motionPending;
	logic accept;
	logic alarm;
	logic timerStart;
	logic timerAbort;
	logic timerExpired;
	logic [15:0] timerMs;
	logic blockDone;
	logic apbWrite;
	logic [2:0] events;

	// Pins from the logic controller cross into this clock through two flip-flops.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			completeMeta <= 1'b0;
			completeSync <= 1'b0;
			lockMeta <= 1'b0;
			lockSync <= 1'b0;
		end
		else
		begin
			completeMeta <= functionComplete;
			completeSync <= completeMeta;
			lockMeta <= auxLockout;
			lockSync <= lockMeta;
		end
	end

	assign blockReady = (state == ST_IDLE) && !cncReset; // R13
	assign accept = blockValid && blockReady;

	always_comb
	begin
		next_mask = '0;
		next_mask[`AFS_FN_AUX] = (blockMCount != 2'h0); // R1
		next_mask[`AFS_FN_SECOND] = tripleEnable && (blockMCount >= 2'h2); // R2
		next_mask[`AFS_FN_THIRD] = tripleEnable && (blockMCount == 2'h3); // R2
		next_mask[`AFS_FN_SPINDLE] = blockSpindleValid; // R16
		next_mask[`AFS_FN_TOOL] = blockToolValid; // R16
		alarm = (!tripleEnable && (blockMCount >= 2'h2)) // R2
			|| (next_mask[`AFS_FN_AUX] && exceedsDigits(blockAux, maxDigits[`AFS_DIGITS_M_LSB +: 4]))
			|| (next_mask[`AFS_FN_SECOND]
				&& exceedsDigits({16'h0, blockSecondAux}, maxDigits[`AFS_DIGITS_M_LSB +: 4]))
			|| (next_mask[`AFS_FN_THIRD]
				&& exceedsDigits({16'h0, blockThirdAux}, maxDigits[`AFS_DIGITS_M_LSB +: 4]))
			|| (next_mask[`AFS_FN_SPINDLE]
				&& exceedsDigits(blockSpindle, maxDigits[`AFS_DIGITS_S_LSB +: 4]))
			|| (next_mask[`AFS_FN_TOOL]
				&& exceedsDigits(blockTool, maxDigits[`AFS_DIGITS_T_LSB +: 4])); // R3
		if (lockSync)
		begin
			next_mask = '0; // R15
		end
	end

	// One timer serves both the strobe delay and the completion hold, which never overlap.
	always_comb
	begin
		timerStart = 1'b0;
		timerMs = strobeDelayMs;
		if (state == ST_IDLE)
		begin
			timerStart = accept && !alarm && (next_mask != '0); // R4
		end
		else if (state == ST_STROBE)
		begin
			timerStart = completeSync; // R10
			timerMs = holdTimeMs;
		end
	end
	assign timerAbort = cncReset || ((state == ST_HOLD) && !completeSync);

	afs_ms_timer #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_timer (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(timerStart),
		.abort(timerAbort),
		.durationMs(timerMs),
		.expired(timerExpired)
	);

	always_ff @(posedge sys_clk)
	begin
		if (reset || cncReset)
		begin
			state <= ST_IDLE; // R17
		end
		else
		begin
			case (state)
				ST_IDLE:
					if (accept && !alarm)
					begin
						state <= (next_mask != '0) ? ST_DELAY : ST_FINISH;
					end
				ST_DELAY:
					if (timerExpired)
					begin
						state <= ST_STROBE;
					end
				ST_STROBE:
					if (completeSync)
					begin
						state <= ST_HOLD;
					end
				ST_HOLD:
					if (!completeSync)
					begin
						state <= ST_STROBE;
					end
					else if (timerExpired)
					begin
						state <= ST_RELEASE;
					end
				ST_RELEASE:
					if (!completeSync)
					begin
						state <= ST_FINISH;
					end
				ST_FINISH:
					if (!motionPending)
					begin
						state <= ST_IDLE; // R13
					end
				default:
					state <= ST_IDLE;
			endcase
		end
	end
	assign blockDone = (state == ST_FINISH) && !motionPending && !cncReset;

	// Code lines carry the binary value from acceptance until completion falls.
	always_ff @(posedge sys_clk)
	begin
		if (reset || cncReset)
		begin
			auxCode <= '0;
			secondAuxCode <= '0;
			thirdAuxCode <= '0;
			spindleCode <= '0;
			toolCode <= '0;
		end
		else if (accept && !alarm)
		begin
			auxCode <= next_mask[`AFS_FN_AUX] ? blockAux : '0; // R5
			secondAuxCode <= next_mask[`AFS_FN_SECOND] ? blockSecondAux : '0;
			thirdAuxCode <= next_mask[`AFS_FN_THIRD] ? blockThirdAux : '0;
			spindleCode <= next_mask[`AFS_FN_SPINDLE] ? blockSpindle : '0;
			toolCode <= next_mask[`AFS_FN_TOOL] ? blockTool : '0;
		end
		else if ((state == ST_RELEASE) && !completeSync)
		begin
			auxCode <= '0; // R12
			secondAuxCode <= '0;
			thirdAuxCode <= '0;
			spindleCode <= '0;
			toolCode <= '0;
		end
	end

	// The strobe set is remembered at acceptance and raised when the delay expires.
	afs_fnmask_t pendingMask;
	always_ff @(posedge sys_clk)
	begin
		if (reset || cncReset)
		begin
			pendingMask <= '0;
			strobeVec <= '0; // R14
		end
		else
		begin
			if (accept && !alarm)
			begin
				pendingMask <= next_mask;
			end
			if ((state == ST_DELAY) && timerExpired)
			begin
				strobeVec <= pendingMask; // R4
			end
			else if ((state == ST_HOLD) && completeSync && timerExpired)
			begin
				strobeVec <= '0; // R10
			end
		end
	end
	assign auxStrobe = strobeVec[`AFS_FN_AUX];
	assign secondAuxStrobe = strobeVec[`AFS_FN_SECOND];
	assign thirdAuxStrobe = strobeVec[`AFS_FN_THIRD];
	assign spindleStrobe = strobeVec[`AFS_FN_SPINDLE];
	assign toolStrobe = strobeVec[`AFS_FN_TOOL];

	always_ff @(posedge sys_clk)
	begin
		if (reset || cncReset)
		begin
			motionStart <= 1'b0;
			motionPending <= 1'b0;
			motionDone <= 1'b0;
		end
		else
		begin
			motionStart <= accept && !alarm && blockHasMotion; // R6
			if (accept && !alarm)
			begin
				motionPending <= blockHasMotion;
				motionDone <= !blockHasMotion;
			end
			else if (motionPending && motionFinished)
			begin
				motionPending <= 1'b0;
				motionDone <= 1'b1; // R8
			end
		end
	end

	// APB: no wait states; read data and error are captured in the setup cycle.
	assign pready = 1'b1;
	assign apbWrite = psel && penable && pwrite;
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			tripleEnable <= 1'b0;
			strobeDelayMs <= `AFS_RST_STROBE_DELAY;
			holdTimeMs <= `AFS_RST_HOLD_TIME;
			maxDigits <= `AFS_RST_DIGITS;
			irqEnable <= 3'h0;
		end
		else if (apbWrite)
		begin
			case (paddr)
				`AFS_ADDR_CTRL: tripleEnable <= pwdata[`AFS_CTRL_TRIPLE_BIT];
				`AFS_ADDR_STROBE_DELAY: strobeDelayMs <= pwdata[15:0];
				`AFS_ADDR_HOLD_TIME: holdTimeMs <= pwdata[15:0];
				`AFS_ADDR_DIGITS: maxDigits <= pwdata[11:0];
				`AFS_ADDR_IRQ_ENABLE: irqEnable <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr <= !isMapped(paddr);
			prdata <= '0;
			case (paddr)
				`AFS_ADDR_CTRL: prdata[`AFS_CTRL_TRIPLE_BIT] <= tripleEnable;
				`AFS_ADDR_STROBE_DELAY: prdata[15:0] <= strobeDelayMs;
				`AFS_ADDR_HOLD_TIME: prdata[15:0] <= holdTimeMs;
				`AFS_ADDR_DIGITS: prdata[11:0] <= maxDigits;
				`AFS_ADDR_STATUS:
				begin
					prdata[`AFS_STATUS_BUSY_BIT] <= (state != ST_IDLE);
					prdata[`AFS_STATUS_MDONE_BIT] <= motionDone;
					prdata[`AFS_STATUS_LOCK_BIT] <= lockSync;
					prdata[`AFS_STATUS_COMPLETE_BIT] <= completeSync;
					prdata[`AFS_STATUS_STROBE_LSB +: 5] <= strobeVec;
				end
				`AFS_ADDR_IRQ_STATUS: prdata[2:0] <= irqStatus;
				`AFS_ADDR_IRQ_ENABLE: prdata[2:0] <= irqEnable;
				default: ;
			endcase
		end
	end

	// Sticky events; a new event wins over a clear written in the same cycle.
	always_comb
	begin
		events = 3'h0;
		events[`AFS_IRQ_ALARM_BIT] = accept && alarm;
		events[`AFS_IRQ_DONE_BIT] = blockDone;
		events[`AFS_IRQ_ABORT_BIT] = cncReset && (state != ST_IDLE);
	end
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			irqStatus <= 3'h0;
		end
		else if (apbWrite && (paddr == `AFS_ADDR_IRQ_CLEAR))
		begin
			irqStatus <= (irqStatus & ~pwdata[2:0]) | events;
		end
		else
		begin
			irqStatus <= irqStatus | events;
		end
	end
	assign irq = |(irqStatus & irqEnable);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	a_strobe_after_delay: assert property ($rose(auxStrobe) |-> $past(state == ST_DELAY && timerExpired)) // R4
		else $error("strobe rose without the delay expiring");
	a_code_held_strobe: assert property (auxStrobe |-> (state == ST_STROBE || state == ST_HOLD)) // R1
		else $error("strobe high outside the handshake");
	a_alarm_no_output: assert property (accept && alarm |=> (state == ST_IDLE) && (strobeVec == '0)) // R3
		else $error("alarmed block started output");
	a_lockout_quiet: assert property (accept && !alarm && lockSync |=> (state == ST_FINISH) && (auxCode == '0)) // R15
		else $error("codes produced under lockout");
	a_hold_release: assert property ($fell(toolStrobe) && !$past(cncReset) |-> $past(state == ST_HOLD && completeSync)) // R10
		else $error("strobe fell before completion was held");
	a_codes_cleared: assert property ((state == ST_RELEASE) && !completeSync && !cncReset |=> (spindleCode == '0) && (auxCode == '0) && (state == ST_FINISH)) // R12
		else $error("codes not cleared after completion fell");
	a_block_wait: assert property (blockReady |-> (state == ST_IDLE) && (strobeVec == '0)) // R13
		else $error("new block offered while busy");
	a_reset_drop: assert property (cncReset |=> (strobeVec == '0) && (state == ST_IDLE) && !motionDone) // R14
		else $error("strobes survived controller reset");
	a_motion_start: assert property (accept && !alarm && blockHasMotion |=> motionStart && !motionDone) // R6
		else $error("motion not started with the block");
	a_single_m: assert property (!tripleEnable && (strobeVec != '0) |-> !secondAuxStrobe && !thirdAuxStrobe) // R2
		else $error("extra M strobe without triple mode");
	a_motion_done: assert property (motionPending && motionFinished && !cncReset && !accept |=> motionDone && !motionPending) // R8
		else $error("motion done not raised");
	a_binary_code: assert property (accept && !alarm && !lockSync |=> (toolCode == $past(blockToolValid ? blockTool : 32'h0))) // R5
		else $error("code lines differ from the command");
	a_reset_idle: assert property (disable iff (1'b0) reset |=> (state == ST_IDLE) && (auxCode == '0) && !auxStrobe && !motionDone) // R17
		else $error("not idle after reset");
endmodule // afs_strobe_ctrl
`default_nettype wire

// ### afs_plc_model.sv
// Behavioural model of the logic controller program that answers the strobe handshake.
// Assumes strobes, codes and motion done come from the controller on the same clock.
`timescale 1ns/10ps
`default_nettype none
module afs_plc_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// From the controller
	input wire logic [4:0] strobes,
	input wire afs_pkg::afs_word_t auxCode,
	input wire logic motionDone,
	// Behaviour chosen by the bench
	input wire logic waitMotion,
	input wire logic [7:0] lat,
	// To the controller and the bench
	output logic functionComplete,
	output afs_pkg::afs_word_t seenAux
);
	import afs_pkg::*;
	logic [7:0] waitCount;
	logic [4:0] prevStrobes;
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			functionComplete <= 1'b0;
			waitCount <= 8'h00;
			prevStrobes <= 5'h00;
			seenAux <= 32'h0;
		end
		else
		begin
			prevStrobes <= strobes;
			if ((strobes & ~prevStrobes) != 5'h00)
				seenAux <= auxCode;
			if (strobes == 5'h00)
			begin
				functionComplete <= 1'b0;
				waitCount <= 8'h00;
			end
			else if (!functionComplete && (motionDone || !waitMotion))
			begin
				waitCount <= waitCount + 8'h01;
				if (waitCount >= lat)
					functionComplete <= 1'b1;
			end
		end
	end
endmodule // afs_plc_model
`default_nettype wire

// ### aux_function_strobe_handshake_bench.sv
// Self-checking bench of the strobe controller facing the logic controller model.
// Assumes the package, the constants header, the design and afs_plc_model compile first.
`timescale 1ns/10ps
`default_nettype none
`include "afs_cfg.svh"
module aux_function_strobe_handshake_bench;
	import afs_pkg::*;
	localparam int N = 4;
	typedef struct {
		logic [1:0] mc;
		logic trip;
		logic mo;
		afs_word_t aux;
		afs_half_t m2;
		afs_half_t m3;
		logic sv;
		afs_word_t s;
		logic tv;
		afs_word_t t;
		logic [4:0] mask;
	} afs_row_s;
	logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, apbErr, blockValid;
	logic blockReady, motionStart, motionFinished, cncReset, functionComplete, auxLockout;
	logic motionDone, irq, auxStrobe, secondAuxStrobe, thirdAuxStrobe, spindleStrobe, toolStrobe;
	logic [11:0] paddr;
	logic [7:0] lat;
	logic [4:0] stb;
	afs_word_t pwdata, prdata, auxCode, spindleCode, toolCode, seenAux, q;
	afs_half_t secondAuxCode, thirdAuxCode;
	afs_row_s cur, x;
	afs_row_s rows [8];
	int badCount, nCompared, i;
	assign stb = {toolStrobe, spindleStrobe, thirdAuxStrobe, secondAuxStrobe, auxStrobe};
	afs_strobe_ctrl #(.CYCLES_PER_MS(N)) dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .blockValid(blockValid), .blockReady(blockReady),
		.blockMCount(cur.mc), .blockAux(cur.aux), .blockSecondAux(cur.m2),
		.blockThirdAux(cur.m3), .blockSpindleValid(cur.sv), .blockSpindle(cur.s),
		.blockToolValid(cur.tv), .blockTool(cur.t), .blockHasMotion(cur.mo),
		.motionStart(motionStart), .motionFinished(motionFinished), .cncReset(cncReset),
		.functionComplete(functionComplete), .auxLockout(auxLockout), .auxCode(auxCode),
		.secondAuxCode(secondAuxCode), .thirdAuxCode(thirdAuxCode), .spindleCode(spindleCode),
		.toolCode(toolCode), .auxStrobe(auxStrobe), .secondAuxStrobe(secondAuxStrobe),
		.thirdAuxStrobe(thirdAuxStrobe), .spindleStrobe(spindleStrobe),
		.toolStrobe(toolStrobe), .motionDone(motionDone), .irq(irq));
	afs_plc_model plc (.sys_clk(sys_clk), .reset(reset), .strobes(stb), .auxCode(auxCode),
		.motionDone(motionDone), .waitMotion(cur.mo), .lat(lat),
		.functionComplete(functionComplete), .seenAux(seenAux));
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task endSim();
		if (badCount == 0 && nCompared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input afs_word_t e, input afs_word_t g);
		nCompared++;
		if (g !== e)
		begin
			badCount++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task guard(input logic ok);
		if (!ok)
		begin
			badCount++;
			$display("mismatch wait expected 1 seen 0");
			endSim();
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input afs_word_t d);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		guard(k < 20);
		q = prdata;
		apbErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input afs_word_t e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg%h", a), e, q);
	endtask
	task run_block(input afs_row_s r, input int dly, input int hold, input logic al);
		int n;
		@(posedge sys_clk);
		cur <= r;
		blockValid <= 1'b1;
		@(negedge sys_clk);
		for (n = 0; n < 3000 && blockReady !== 1'b1; n++) @(negedge sys_clk);
		guard(n < 3000);
		@(posedge sys_clk);
		blockValid <= 1'b0;
		@(negedge sys_clk);
		if (!al)
		begin
			chk("motionStart", r.mo, motionStart);
			chk("motionDone", !r.mo, motionDone);
		end
		if (r.mask != 5'h00)
		begin
			chk("codesWithMotion", 1, |{auxCode, spindleCode, toolCode, secondAuxCode});
			for (n = 0; n < 3000 && stb === 5'h00; n++) @(negedge sys_clk);
			chk("strobeDelay", dly * N + 1, n);
			chk("strobes", r.mask, stb);
			chk("auxCode", r.mask[0] ? r.aux : 32'h0, auxCode);
			chk("secondAuxCode", r.mask[1] ? r.m2 : 16'h0, secondAuxCode);
			chk("thirdAuxCode", r.mask[2] ? r.m3 : 16'h0, thirdAuxCode);
			chk("spindleCode", r.mask[3] ? r.s : 32'h0, spindleCode);
			chk("toolCode", r.mask[4] ? r.t : 32'h0, toolCode);
			chk("blockReady", 0, blockReady);
			for (n = 0; n < 3000 && functionComplete !== 1'b1; n++) @(negedge sys_clk);
			for (n = 0; n < 3000 && stb !== 5'h00; n++) @(negedge sys_clk);
			chk("holdWindow", 1, n > hold * N && n <= hold * N + 4);
		end
		else
		begin
			for (n = 0; n < 40; n++)
			begin
				@(negedge sys_clk);
				if (stb !== 5'h00 || auxCode !== 32'h0)
					break;
			end
			chk("silentCycles", 40, n);
		end
		for (n = 0; n < 3000 && blockReady !== 1'b1; n++) @(negedge sys_clk);
		guard(n < 3000);
		chk("codesCleared", 0, auxCode | spindleCode | toolCode | {secondAuxCode, thirdAuxCode});
		if (r.mask != 5'h00)
			chk("seenAux", r.mask[0] ? r.aux : 32'h0, seenAux);
	endtask
	initial
	begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		blockValid = 1'b0;
		motionFinished = 1'b0;
		cncReset = 1'b0;
		auxLockout = 1'b0;
		lat = 8'h02;
		badCount = 0;
		nCompared = 0;
		rows = '{
			'{2'h1, 1'b0, 1'b0, 32'h3, 16'h0, 16'h0, 1'b0, 32'h0, 1'b0, 32'h0, 5'h01},
			'{2'h3, 1'b1, 1'b0, 32'h5, 16'h6, 16'h7, 1'b1, 32'h4B0, 1'b1, 32'h603, 5'h1F},
			'{2'h0, 1'b0, 1'b0, 32'h0, 16'h0, 16'h0, 1'b1, 32'h5F5E0FF, 1'b0, 32'h0, 5'h08},
			'{2'h2, 1'b1, 1'b0, 32'h5F5E0FF, 16'h10, 16'h22, 1'b0, 32'h0, 1'b1, 32'h1, 5'h13},
			'{2'h1, 1'b1, 1'b0, 32'h1, 16'h33, 16'h44, 1'b0, 32'h0, 1'b0, 32'h0, 5'h01},
			'{2'h1, 1'b0, 1'b0, 32'h5F5E100, 16'h0, 16'h0, 1'b0, 32'h0, 1'b0, 32'h0, 5'h00},
			'{2'h2, 1'b0, 1'b0, 32'h1, 16'h1, 16'h0, 1'b0, 32'h0, 1'b0, 32'h0, 5'h00},
			'{2'h0, 1'b0, 1'b0, 32'h0, 16'h0, 16'h0, 1'b1, 32'h5F5E100, 1'b0, 32'h0, 5'h00}};
		cur = rows[0];
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		chk("strobes", 0, stb);
		chk("codes", 0, auxCode | toolCode | spindleCode);
		chk("motionDone", 0, motionDone);
		rd(`AFS_ADDR_CTRL, 32'h0);
		rd(`AFS_ADDR_STROBE_DELAY, 32'h40);
		rd(`AFS_ADDR_HOLD_TIME, 32'h8);
		rd(`AFS_ADDR_DIGITS, 32'h888);
		rd(`AFS_ADDR_STATUS, 32'h0);
		rd(12'h020, 32'h0);
		chk("pslverr", 1, apbErr);
		run_block(rows[0], 64, 8, 1'b0);
		apb(1'b1, `AFS_ADDR_STROBE_DELAY, 32'h1);
		apb(1'b1, `AFS_ADDR_HOLD_TIME, 32'h1);
		for (i = 0; i < 5; i++)
		begin
			apb(1'b1, `AFS_ADDR_CTRL, {31'h0, rows[i].trip});
			run_block(rows[i], 1, 1, 1'b0);
		end
		chk("irq", 0, irq);
		rd(`AFS_ADDR_IRQ_STATUS, 32'h2);
		apb(1'b1, `AFS_ADDR_IRQ_ENABLE, 32'h2);
		@(negedge sys_clk);
		chk("irq", 1, irq);
		apb(1'b1, `AFS_ADDR_IRQ_CLEAR, 32'h7);
		@(negedge sys_clk);
		chk("irq", 0, irq);
		rd(`AFS_ADDR_IRQ_STATUS, 32'h0);
		apb(1'b1, `AFS_ADDR_CTRL, 32'h0);
		apb(1'b1, `AFS_ADDR_IRQ_ENABLE, 32'h1);
		for (i = 5; i < 8; i++)
		begin
			run_block(rows[i], 1, 1, 1'b1);
			chk("alarmIrq", 1, irq);
			apb(1'b1, `AFS_ADDR_IRQ_CLEAR, 32'h7);
			@(negedge sys_clk);
			chk("alarmIrq", 0, irq);
		end
		@(posedge sys_clk);
		auxLockout <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(`AFS_ADDR_STATUS, 32'h6);
		x = rows[1];
		x.mask = 5'h00;
		apb(1'b1, `AFS_ADDR_CTRL, 32'h1);
		run_block(x, 1, 1, 1'b0);
		@(posedge sys_clk);
		auxLockout <= 1'b0;
		// The lockout pin needs two more edges through the synchroniser before a block is offered.
		repeat (3) @(posedge sys_clk);
		x = rows[0];
		x.mo = 1'b1;
		fork
			run_block(x, 1, 1, 1'b0);
			begin
				for (i = 0; i < 3000 && stb === 5'h00; i++) @(negedge sys_clk);
				repeat (10) @(negedge sys_clk);
				chk("completeBeforeMotion", 0, functionComplete);
				chk("motionDone", 0, motionDone);
				@(posedge sys_clk);
				motionFinished <= 1'b1;
				@(posedge sys_clk);
				motionFinished <= 1'b0;
			end
		join
		chk("motionDone", 1, motionDone);
		@(posedge sys_clk);
		lat <= 8'hC8;
		cur <= rows[0];
		blockValid <= 1'b1;
		@(posedge sys_clk);
		blockValid <= 1'b0;
		for (i = 0; i < 3000 && stb === 5'h00; i++) @(negedge sys_clk);
		guard(i < 3000);
		@(posedge sys_clk);
		cncReset <= 1'b1;
		@(posedge sys_clk);
		cncReset <= 1'b0;
		@(negedge sys_clk);
		chk("strobesAfterAbort", 0, stb);
		chk("codesAfterAbort", 0, auxCode);
		apb(1'b0, `AFS_ADDR_IRQ_STATUS, 32'h0);
		chk("abortFlag", 32'h4, q & 32'h4);
		lat <= 8'h02;
		reset <= 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		rd(`AFS_ADDR_STROBE_DELAY, 32'h40);
		rd(`AFS_ADDR_IRQ_STATUS, 32'h0);
		endSim();
	end
endmodule // aux_function_strobe_handshake_bench
`default_nettype wire
